// >>> inc/adc_readout_pkg.sv
// shared constants and types for the converter serial readout block
package adc_readout_pkg;

    // result word width and the falling-edge schedule of one frame
    localparam int RESULT_WIDTH    = 12;
    localparam int NULL_EDGE       = 2;
    localparam int FIRST_MSB_EDGE  = 3;

    // reset values
    localparam logic SELECT_IDLE   = 1'b1;
    localparam logic DOUT_RESET    = 1'b0;

    // core clock rate and the shortest complete sample-and-transfer cycle
    localparam int CORE_CLK_MHZ    = 250;
    localparam int MIN_CYCLE_US    = 64;
    localparam int MIN_CYCLE_CYC   = MIN_CYCLE_US * CORE_CLK_MHZ;

    // power state seen by the analog side
    typedef struct packed {
        logic awake;
        logic bias_on;
        logic ref_hiz;
    } power_state_type;

    localparam power_state_type POWER_RESET = '{
        awake:   1'b0,
        bias_on: 1'b0,
        ref_hiz: 1'b1
    };

endpackage

// >>> logic/adc_link_shifter.sv
// link-side shifter running on the host's shift clock
`timescale 1ns/100ps
`default_nettype none

module adc_link_shifter
    import adc_readout_pkg::*;
#(
    parameter int WIDTH = RESULT_WIDTH
) (
    input  wire logic             i_shift_clock,
    input  wire logic             i_select_n_powerdown,
    input  wire logic [WIDTH-1:0] i_word,
    output var  logic             o_dout,
    output var  logic             o_dout_oe,
    output var  logic             o_conv_done
);

    localparam int LSB_EDGE  = FIRST_MSB_EDGE + WIDTH - 1;
    localparam int LAST_EDGE = LSB_EDGE + WIDTH - 1;
    localparam int SAT_EDGE  = LAST_EDGE + 1;
    localparam int CW        = $clog2(SAT_EDGE + 1);
    localparam logic [CW-1:0] SAT_CNT  = CW'(SAT_EDGE);
    localparam logic [CW-1:0] NULL_CNT = CW'(NULL_EDGE);
    localparam logic [CW-1:0] LSB_CNT  = CW'(LSB_EDGE);

    // bit driven on falling edge number e: msb first, then lsb first, then 0
    function automatic logic bit_for_edge(input logic [CW-1:0] e,
                                          input logic [WIDTH-1:0] w);
        int n;
        n = int'(e);
        bit_for_edge = 1'b0;
        if (n >= FIRST_MSB_EDGE && n <= LSB_EDGE) begin
            bit_for_edge = w[LSB_EDGE - n];
        end else if (n > LSB_EDGE && n <= LAST_EDGE) begin
            bit_for_edge = w[n - LSB_EDGE];
        end
    endfunction

    logic [CW-1:0]    edge_cnt_reg;
    logic [WIDTH-1:0] word_reg;
    wire  [CW-1:0]    edge_cnt_next;
    wire              null_edge;
    wire              oe_next;
    wire              dout_next;
    wire  [WIDTH-1:0] word_next;

    assign edge_cnt_next = (edge_cnt_reg == SAT_CNT) ? edge_cnt_reg
                                                     : edge_cnt_reg + 1'b1;
    assign null_edge = (edge_cnt_next == NULL_CNT);
    assign oe_next   = o_dout_oe | null_edge; // RL3
    assign word_next = null_edge ? i_word : word_reg;
    // the null edge itself drives 0, the word follows from the next edge
    assign dout_next = bit_for_edge(edge_cnt_next, word_reg); // RL4

    // select high is the frame's own reset: the clock may stop outside frames
    always_ff @(negedge i_shift_clock or posedge i_select_n_powerdown) begin
        if (i_select_n_powerdown) begin // RL6
            edge_cnt_reg <= '0;
            word_reg     <= '0;
            o_dout       <= DOUT_RESET;
            o_dout_oe    <= 1'b0; // RL13
            o_conv_done  <= 1'b0;
        end else begin // RL1 RL2
            edge_cnt_reg <= edge_cnt_next;
            word_reg     <= word_next;
            o_dout       <= dout_next; // RL5 RL9 RL14
            o_dout_oe    <= oe_next;
            o_conv_done  <= o_conv_done | (edge_cnt_next == LSB_CNT); // RL8
        end
    end

    if (WIDTH < 2 || WIDTH > 32) begin : gen_bad_width
        $error("link shifter width out of range");
    end

    property p_link(logic a, logic b);
        @(negedge i_shift_clock) disable iff (i_select_n_powerdown) a |-> b;
    endproperty

    oe_before_null_a: assert property (p_link(edge_cnt_reg < NULL_CNT, // RL3
                                              !o_dout_oe))
        else $error("output enabled before second pulse");
    null_bit_zero_a: assert property (p_link(edge_cnt_reg == NULL_CNT, // RL4
                                             o_dout_oe && !o_dout))
        else $error("null bit not low");
    msb_pass_a: assert property (@(negedge i_shift_clock) // RL14
        disable iff (i_select_n_powerdown)
        (edge_cnt_reg == NULL_CNT) ##1 (edge_cnt_reg > NULL_CNT) |->
            o_dout == word_reg[WIDTH-1])
        else $error("first data bit is not the msb");
    zero_tail_a: assert property (p_link(edge_cnt_reg == SAT_CNT, // RL9
                                         o_dout == 1'b0))
        else $error("tail bits not zero");
    done_at_lsb_a: assert property (p_link(edge_cnt_reg >= LSB_CNT, // RL8
                                           o_conv_done))
        else $error("conversion done not flagged after lsb");
    cover_full_frame: cover property (@(negedge i_shift_clock)
        disable iff (i_select_n_powerdown) edge_cnt_reg == SAT_CNT);

endmodule

`default_nettype wire

// >>> logic/adc_serial_readout.sv
// core-side readout and power control of the serial sampling converter
`timescale 1ns/100ps
`default_nettype none

// Operation
// RL1: output changes on falling edge, host samples rising
// RL2: select falling starts a sample-and-transfer sequence
// RL3: output disabled until second clock pulse
// RL4: one null bit precedes the result
// RL5: twelve result bits, one per falling edge
// RL6: select high aborts and resets the interface
// RL7: powered only while select is low
// RL8: bias and reference shut down after conversion
// RL9: continued clocking gives lsb-first word, then zeros
// RL10: host clock paces transfer and conversion
// RL11: host keeps select low time short
// RL12: host cycles no faster than 64 us
// RL13: output high impedance while select high
// RL14: msb first, lsb shared with lsb-first pass
module adc_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int WIDTH      = RESULT_WIDTH,
    parameter int MIN_CYCLES = MIN_CYCLE_CYC
) (
    input  wire logic                             i_core_clk,
    input  wire logic                             i_reset,
    input  wire logic                             i_shift_clock,
    input  wire logic                             i_select_n_powerdown,
    input  wire logic [WIDTH-1:0]                 i_conv_result,
    output var  logic                             o_dout,
    output var  logic                             o_dout_oe,
    output var  adc_readout_pkg::power_state_type o_power,
    output var  logic                             o_short_cycle
);
    import adc_readout_pkg::*;

    localparam int MCW = $clog2(MIN_CYCLES + 1);
    localparam logic [MCW-1:0] MIN_CNT = MCW'(MIN_CYCLES);

    // parameters that the counters and the link cannot serve stop the build
    if (MIN_CYCLES < 1) begin : gen_bad_min_cycles
        $error("minimum cycle count must be positive");
    end
    if (WIDTH < 2 || WIDTH > 32) begin : gen_bad_width
        $error("result width out of range");
    end

    // select pin and conversion-done level cross into the core clock
    logic select_meta_reg;
    logic select_sync_reg;
    logic select_d_reg;
    logic done_meta_reg;
    logic done_sync_reg;
    logic             link_done;
    logic [WIDTH-1:0] snapshot_reg;
    logic [MCW-1:0]   cycle_cnt_reg;

    wire              selected;
    wire              frame_start;
    wire [WIDTH-1:0]  snapshot_next;
    wire [MCW-1:0]    cycle_cnt_next;
    wire              short_next;
    wire              bias_next;
    power_state_type  power_next;

    assign selected    = ~select_sync_reg;
    assign frame_start = select_d_reg & ~select_sync_reg; // RL2

    // the word is frozen as soon as a frame is seen, well before the
    // link reads it on the null edge; the host's setup time covers the gap
    assign snapshot_next = selected ? snapshot_reg : i_conv_result;

    // the host owns the rate; this only reports a cycle that came too soon
    assign cycle_cnt_next = frame_start ? '0 :
                            (cycle_cnt_reg == MIN_CNT) ? cycle_cnt_reg :
                            cycle_cnt_reg + 1'b1;
    assign short_next = o_short_cycle |
                        (frame_start && cycle_cnt_reg != MIN_CNT); // RL12

    // bias and reference come from one level so they can never disagree
    assign bias_next  = selected & ~done_sync_reg; // RL8
    assign power_next = {selected, bias_next, ~bias_next}; // RL7 RL8

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    // first stages carry no reset: they only ever follow the select pin and the link's done level
    always_ff @(posedge i_core_clk) begin
        select_meta_reg <= i_select_n_powerdown;
        done_meta_reg   <= link_done;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            select_sync_reg <= SELECT_IDLE;
            select_d_reg    <= SELECT_IDLE;
            done_sync_reg   <= 1'b0;
        end else begin
            select_sync_reg <= select_meta_reg;
            select_d_reg    <= select_sync_reg;
            done_sync_reg   <= done_meta_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            snapshot_reg <= '0;
        end else begin
            snapshot_reg <= snapshot_next;
        end
    end

    snapshot_tracks_a: assert property ( // RL5
        !selected |=> snapshot_reg == $past(i_conv_result))
        else $error("result word not sampled while deselected");

    snapshot_frozen_a: assert property ( // RL5
        selected && $past(selected) |-> $stable(snapshot_reg))
        else $error("result word changed inside a frame");

    // saturating, so a long idle gap never wraps into a false short cycle
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cycle_cnt_reg <= MIN_CNT;
            o_short_cycle <= 1'b0;
        end else begin
            cycle_cnt_reg <= cycle_cnt_next;
            o_short_cycle <= short_next;
        end
    end

    cycle_restart_a: assert property ( // RL12
        frame_start |=> cycle_cnt_reg == '0)
        else $error("cycle counter not restarted by a frame");

    cycle_hold_a: assert property ( // RL12
        !frame_start && cycle_cnt_reg == MIN_CNT |=> cycle_cnt_reg == MIN_CNT)
        else $error("cycle counter left saturation");

    short_sticky_a: assert property ( // RL12
        frame_start && cycle_cnt_reg != MIN_CNT |=> o_short_cycle [*2])
        else $error("short cycle not flagged");

    short_quiet_a: assert property ( // RL12
        !o_short_cycle && !(frame_start && cycle_cnt_reg != MIN_CNT)
        |=> !o_short_cycle)
        else $error("short cycle flagged without a short cycle");

    // awake lags the pin by three core cycles: two sync stages, this flop
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_power <= POWER_RESET;
        end else begin
            o_power <= power_next;
        end
    end

    awake_follows_a: assert property ( // RL7
        select_sync_reg |=> !o_power.awake)
        else $error("awake while deselected");

    awake_on_select_a: assert property ( // RL7
        !select_sync_reg |=> o_power.awake)
        else $error("not awake while selected");

    deselect_off_a: assert property ( // RL7
        select_sync_reg |=> !o_power.bias_on && o_power.ref_hiz)
        else $error("bias on while deselected");

    bias_off_done_a: assert property ( // RL8
        done_sync_reg |=> !o_power.bias_on && o_power.ref_hiz)
        else $error("bias still on after conversion");

    bias_on_active_a: assert property ( // RL8
        !select_sync_reg && !done_sync_reg |=> o_power.bias_on)
        else $error("bias off before the conversion ended");

    ref_pairs_bias_a: assert property ( // RL8
        o_power.ref_hiz == !o_power.bias_on)
        else $error("reference state disagrees with bias");

    // the link clock paces both shifting and conversion
    adc_link_shifter #(
        .WIDTH (WIDTH)
    ) u_link ( // RL10
        .i_shift_clock        (i_shift_clock),
        .i_select_n_powerdown (i_select_n_powerdown),
        .i_word               (snapshot_reg),
        .o_dout               (o_dout),
        .o_dout_oe            (o_dout_oe),
        .o_conv_done          (link_done)
    );

    // the link domain is checked here only at core edges, well after select
    idle_hiz_a: assert property ( // RL13
        select_sync_reg && select_d_reg |-> !o_dout_oe)
        else $error("output driven while deselected");

    dout_quiet_a: assert property ( // RL13
        select_sync_reg && select_d_reg |-> !o_dout)
        else $error("serial data not low while deselected");

    oe_released_a: assert property ( // RL6
        $rose(select_sync_reg) |-> !o_dout_oe)
        else $error("output still enabled after deselect");

    done_clears_a: assert property ( // RL6
        select_sync_reg && select_d_reg |-> !done_sync_reg)
        else $error("conversion done kept after deselect");

    cover_frame_start: cover property (frame_start);
    cover_auto_down: cover property (
        o_power.awake && !o_power.bias_on);
    cover_short: cover property ($rose(o_short_cycle));
    cover_link_done: cover property (done_sync_reg);

endmodule

`default_nettype wire

// >>> tb/adc_host_model.sv
// host model: drives select and shift clock, samples the serial line
`timescale 1ns/100ps
`default_nettype none

module adc_host_model (
    input  wire logic i_dout,
    input  wire logic i_dout_oe,
    output var  logic o_shift_clock,
    output var  logic o_select_n_powerdown
);
    logic oe_log [1:40];
    logic bit_log[1:40];
    logic line_level;
    int   edges;
    int   half_ns;

    initial begin
        o_shift_clock = 1'b0;
        o_select_n_powerdown = 1'b1;
        line_level = 1'b0;
        edges = 0;
        half_ns = 6;
    end

    // no pull on the line: a released line shows the inverse of its last level
    task automatic take();
        line_level = i_dout_oe ? i_dout : ~line_level;
        oe_log[edges] = i_dout_oe;
        bit_log[edges] = line_level;
    endtask

    task automatic start();
        edges = 0;
        o_select_n_powerdown = 1'b0;
        // odd offset keeps link edges off the core clock edges when start is entered at an even time, which is not so for frame(3)
        #21;
    endtask

    // clock stands still low between calls; each bit is taken at the rise, the last one half a period after the last fall
    task automatic pulses(input int n);
        repeat (n) begin
            o_shift_clock = 1'b1;
            if (edges > 0) take();
            #(half_ns) o_shift_clock = 1'b0;
            edges++;
            #(half_ns);
        end
        take();
    endtask

    // high time keeps frames apart, as the device needs to settle
    task automatic stop();
        o_select_n_powerdown = 1'b1;
        #40;
    endtask
endmodule

`default_nettype wire

// >>> tb/adc_serial_readout_shutdown_bench.sv
// self-checking bench of the serial readout and power control block
`timescale 1ns/100ps
`default_nettype none

module adc_serial_readout_shutdown_bench;
    import adc_readout_pkg::*;
    localparam int MIN_SIM = 50;
    localparam int LSB_EDGE = FIRST_MSB_EDGE + RESULT_WIDTH - 1;
    logic                    clk;
    logic                    reset;
    logic                    shift_clock;
    logic                    select_n;
    logic                    dout;
    logic                    dout_oe;
    logic                    short_cycle;
    logic [RESULT_WIDTH-1:0] word;
    power_state_type         power;
    int                      num_errors;
    int                      checks;
    int                      seed;

    adc_serial_readout #(.WIDTH(RESULT_WIDTH), .MIN_CYCLES(MIN_SIM))
        adc_serial_readout_i (
        .i_core_clk           (clk),
        .i_reset              (reset),
        .i_shift_clock        (shift_clock),
        .i_select_n_powerdown (select_n),
        .i_conv_result        (word),
        .o_dout               (dout),
        .o_dout_oe            (dout_oe),
        .o_power              (power),
        .o_short_cycle        (short_cycle)
    );

    adc_host_model adc_host_model_i (
        .i_dout               (dout),
        .i_dout_oe            (dout_oe),
        .o_shift_clock        (shift_clock),
        .o_select_n_powerdown (select_n)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // line level after falling edge k: null, msb-first, lsb-first, zeros
    function automatic logic exp_bit(input logic [11:0] w, input int k);
        if (k >= FIRST_MSB_EDGE && k <= LSB_EDGE)
            return w[LSB_EDGE - k];
        if (k > LSB_EDGE && k < LSB_EDGE + RESULT_WIDTH)
            return w[k - LSB_EDGE];
        return 1'b0;
    endfunction

    task automatic frame(input int n);
        adc_host_model_i.start();
        adc_host_model_i.pulses(n < 5 ? n : 5);
        if (n >= 5) check({9'h0, power}, 12'h006);
        if (n > 5) adc_host_model_i.pulses(n - 5);
        #20;
        if (n > LSB_EDGE) check({9'h0, power}, 12'h005);
        for (int k = 1; k <= n; k++) begin
            logic oe_seen;
            logic bit_seen;
            logic bit_exp;
            oe_seen  = adc_host_model_i.oe_log[k];
            bit_seen = adc_host_model_i.bit_log[k];
            bit_exp  = exp_bit(word, k);
            check(12'(oe_seen), 12'(k >= NULL_EDGE));
            if (k >= NULL_EDGE) begin
                check(12'(bit_seen), 12'(bit_exp));
            end
        end
        adc_host_model_i.stop();
        check({10'h0, dout_oe, dout}, 12'h000);
        check({9'h0, power}, {9'h0, POWER_RESET});
    endtask

    task automatic do_reset();
        @(negedge clk) reset <= 1'b1;
        repeat (2) @(negedge clk);
        reset <= 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a healthy run takes some microseconds; this cuts a hang short
    initial begin
        #100000;
        num_errors++;
        finish_test();
    end

    initial begin
        seed = 32'hC571A705;
        num_errors = 0;
        checks = 0;
        reset = 1'b1;
        word = 12'h000;
        do_reset();
        word = 12'hFFF;
        frame(30);
        @(negedge clk) word <= 12'h000;
        frame(26);
        @(negedge clk) word <= 12'hA5C;
        frame(14);
        adc_host_model_i.half_ns = 18;
        @(negedge clk) word <= 12'h3C1;
        frame(25);
        repeat (8) begin
            adc_host_model_i.half_ns = ($random(seed) & 1) ? 18 : 6;
            @(negedge clk) word <= 12'($random(seed));
            frame(14 + int'($unsigned($random(seed)) % 17));
        end
        check({11'h0, short_cycle}, 12'h000);
        frame(3);
        frame(1);
        check({11'h0, short_cycle}, 12'h001);
        do_reset();
        check({11'h0, short_cycle}, 12'h000);
        finish_test();
    end
endmodule

`default_nettype wire
